// >>> core/dcf_code_conv.sv
// Purpose: convert one written code into the straight binary core code
// Assumes: format enum from the package
// Notes: combinational, used for channel and offset codes alike
`timescale 1ns/1ps
module dcf_code_conv (
  input wire dcf_pkg::dcf_fmt_e i_fmt,
  input wire logic [15:0] i_code,
  output logic [15:0] o_core
);

  // twos complement to offset binary is only the sign bit flipped
  always_comb begin
    if (i_fmt == dcf_pkg::DCF_FMT_BTC) begin
      o_core = i_code ^ dcf_pkg::SIGN_MASK;
    end else begin
      o_core = i_code;
    end
  end

endmodule // dcf_code_conv

// >>> core/dcf_format_offset.sv
// Purpose: code format selection, offset code defaults and core code outputs
// Assumes: format and supply straps are quasi-static pins, synchronised here
// Notes: registers hold codes as written, but a format change flips both offset sign bits; the core sees straight binary
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module dcf_format_offset #(
  parameter int NUM_CH = dcf_pkg::NUM_CH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_code_format_select_pin,
  input wire logic i_single_supply,
  input wire dcf_pkg::dcf_bus_req_s i_bus,
  output logic [15:0] o_rdata,
  output dcf_pkg::dcf_core_s o_core,
  output logic o_ofs_amp_en
);

  typedef struct packed {
    logic [1:0] fmt_sync;
    logic [1:0] single_sync;
    logic fmt_btc;
    logic single;
    logic [NUM_CH-1:0][15:0] ch;
    logic [15:0] ofs_a;
    logic [15:0] ofs_b;
    logic [15:0] gain_cor;
    logic [15:0] zero_cor;
    logic gain6;
    logic init_pend;
    logic [15:0] rdata;
  } dcf_state_s;

  dcf_state_s state_ff;
  dcf_state_s nxt_state;
  dcf_pkg::dcf_fmt_e fmt;
  logic [NUM_CH-1:0][15:0] ch_core;
  logic [15:0] ofs_a_core;
  logic [15:0] ofs_b_core;
  logic [15:0] ofs_def_usb;
  logic [15:0] ofs_def;
  logic [15:0] status_word;

  assign fmt = state_ff.fmt_btc ? dcf_pkg::DCF_FMT_BTC : dcf_pkg::DCF_FMT_USB;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      dcf_code_conv u_conv (
        .i_fmt(fmt),
        .i_code(state_ff.ch[gi]),
        .o_core(ch_core[gi])
      );
    end
  endgenerate

  // offset codes follow the same pin as the channel codes
  dcf_code_conv u_conv_ofs_a (
    .i_fmt(fmt),
    .i_code(state_ff.ofs_a),
    .o_core(ofs_a_core)
  );

  dcf_code_conv u_conv_ofs_b (
    .i_fmt(fmt),
    .i_code(state_ff.ofs_b),
    .o_core(ofs_b_core)
  );

  // default kept as binary and expressed in the selected format
  always_comb begin
    ofs_def_usb = state_ff.gain6 ? dcf_pkg::OFS_DEF_G6 : dcf_pkg::OFS_DEF_G4;
    if (state_ff.fmt_btc) begin
      ofs_def = ofs_def_usb ^ dcf_pkg::SIGN_MASK;
    end else begin
      ofs_def = ofs_def_usb;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[dcf_pkg::STS_FMT_BIT] = state_ff.fmt_btc;
    status_word[dcf_pkg::STS_SINGLE_BIT] = state_ff.single;
    status_word[dcf_pkg::STS_GAIN_BIT] = state_ff.gain6;
    status_word[dcf_pkg::STS_OFS_EN_BIT] = ~state_ff.single;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.fmt_sync = {state_ff.fmt_sync[0], i_code_format_select_pin};
    nxt_state.single_sync = {state_ff.single_sync[0], i_single_supply};
    nxt_state.fmt_btc = state_ff.fmt_sync[1];
    nxt_state.single = state_ff.single_sync[1];
    nxt_state.rdata = '0;
    nxt_state.init_pend = 1'b0;

    // first load after reset comes one edge after release, in the binary format that reset leaves set
    if (state_ff.init_pend) begin
      nxt_state.ofs_a = ofs_def;
      nxt_state.ofs_b = ofs_def;
    end

    // a format change after reset flips the sign bit of both stored offsets
    if (!state_ff.init_pend && (state_ff.fmt_btc != state_ff.fmt_sync[1])) begin
      nxt_state.ofs_a = state_ff.ofs_a ^ dcf_pkg::SIGN_MASK;
      nxt_state.ofs_b = state_ff.ofs_b ^ dcf_pkg::SIGN_MASK;
    end

    if (i_bus.wr) begin
      if (i_bus.addr < dcf_pkg::ADDR_OFS_A) begin
        nxt_state.ch[i_bus.addr[2:0]] = i_bus.wdata;
      end
      unique case (i_bus.addr)
        dcf_pkg::ADDR_OFS_A: begin
          nxt_state.ofs_a = i_bus.wdata;
        end
        dcf_pkg::ADDR_OFS_B: begin
          nxt_state.ofs_b = i_bus.wdata;
        end
        dcf_pkg::ADDR_GAIN_COR: begin
          nxt_state.gain_cor = i_bus.wdata;
        end
        dcf_pkg::ADDR_ZERO_COR: begin
          nxt_state.zero_cor = i_bus.wdata;
        end
        dcf_pkg::ADDR_CONFIG: begin
          nxt_state.gain6 = i_bus.wdata[dcf_pkg::CFG_GAIN_BIT];
          if (i_bus.wdata[dcf_pkg::CFG_GAIN_BIT] != state_ff.gain6) begin
            // reload uses the new gain's default in the current format
            nxt_state.ofs_a = (i_bus.wdata[dcf_pkg::CFG_GAIN_BIT] ? dcf_pkg::OFS_DEF_G6
                                : dcf_pkg::OFS_DEF_G4) ^ (state_ff.fmt_btc ? dcf_pkg::SIGN_MASK
                                : 16'h0000);
            nxt_state.ofs_b = nxt_state.ofs_a;
          end
        end
        default: begin
        end
      endcase
    end

    if (i_bus.rd) begin
      if (i_bus.addr < dcf_pkg::ADDR_OFS_A) begin
        nxt_state.rdata = state_ff.ch[i_bus.addr[2:0]];
      end
      unique case (i_bus.addr)
        dcf_pkg::ADDR_OFS_A: nxt_state.rdata = state_ff.ofs_a;
        dcf_pkg::ADDR_OFS_B: nxt_state.rdata = state_ff.ofs_b;
        dcf_pkg::ADDR_GAIN_COR: nxt_state.rdata = state_ff.gain_cor;
        dcf_pkg::ADDR_ZERO_COR: nxt_state.rdata = state_ff.zero_cor;
        dcf_pkg::ADDR_CONFIG: nxt_state.rdata = {15'h0000, state_ff.gain6};
        dcf_pkg::ADDR_STATUS: nxt_state.rdata = status_word;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_ff <= '0;
      state_ff.gain6 <= dcf_pkg::CFG_GAIN_RST;
      state_ff.gain_cor <= dcf_pkg::GAIN_COR_RST;
      state_ff.zero_cor <= dcf_pkg::ZERO_COR_RST;
      state_ff.ofs_a <= dcf_pkg::OFS_DEF_G6;
      state_ff.ofs_b <= dcf_pkg::OFS_DEF_G6;
      state_ff.init_pend <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // offset path off on a single supply; offset core codes held at zero there
  always_comb begin
    o_core.ch_core = ch_core;
    o_core.ofs_a_core = state_ff.single ? 16'h0000 : ofs_a_core;
    o_core.ofs_b_core = state_ff.single ? 16'h0000 : ofs_b_core;
    o_core.gain_cor = state_ff.gain_cor;
    o_core.zero_cor = state_ff.zero_cor;
    o_core.gain6 = state_ff.gain6;
    o_core.ofs_en = ~state_ff.single;
  end

  assign o_ofs_amp_en = ~state_ff.single;
  assign o_rdata = state_ff.rdata;

endmodule // dcf_format_offset

// >>> core/dcf_pkg.sv
// Purpose: shared constants and carriers for the code format and offset block
// Assumes: 16-bit codes, two channel groups of four channels
// Notes: offset defaults are straight binary nominal values
package dcf_pkg;

  localparam int CODE_W = 16;
  localparam int NUM_CH = 8;
  localparam int CH_PER_GRP = 4;

  // register addresses on the plain port
  localparam logic [3:0] ADDR_CH0 = 4'h0;
  localparam logic [3:0] ADDR_OFS_A = 4'h8;
  localparam logic [3:0] ADDR_OFS_B = 4'h9;
  localparam logic [3:0] ADDR_GAIN_COR = 4'hA;
  localparam logic [3:0] ADDR_ZERO_COR = 4'hB;
  localparam logic [3:0] ADDR_CONFIG = 4'hC;
  localparam logic [3:0] ADDR_STATUS = 4'hD;

  // config and status field positions
  localparam int CFG_GAIN_BIT = 0;
  localparam int STS_FMT_BIT = 0;
  localparam int STS_SINGLE_BIT = 1;
  localparam int STS_GAIN_BIT = 2;
  localparam int STS_OFS_EN_BIT = 3;

  // values after reset, the gain-4 offset default and code constants
  localparam logic [15:0] OFS_DEF_G6 = 16'h999A;
  localparam logic [15:0] OFS_DEF_G4 = 16'hAAAB;
  localparam logic [15:0] GAIN_COR_RST = 16'h8000;
  localparam logic [15:0] ZERO_COR_RST = 16'h0000;
  localparam logic [15:0] CH_RST = 16'h0000;
  localparam logic [15:0] CODE_ZERO_USB = 16'h8000;
  localparam logic [15:0] CODE_ZERO_BTC = 16'h0000;
  localparam logic CFG_GAIN_RST = 1'b1;
  localparam logic [15:0] SIGN_MASK = 16'h8000;

  typedef enum logic [1:0] {
    DCF_FMT_USB = 2'b01,
    DCF_FMT_BTC = 2'b10
  } dcf_fmt_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dcf_bus_req_s;

  typedef struct packed {
    logic [7:0][15:0] ch_core;
    logic [15:0] ofs_a_core;
    logic [15:0] ofs_b_core;
    logic [15:0] gain_cor;
    logic [15:0] zero_cor;
    logic gain6;
    logic ofs_en;
  } dcf_core_s;

endpackage

// >>> dv/dcf_format_offset_assertions.sv
// Purpose: port checks for the format and offset block
// Assumes: one clock, sync active-low reset
// Notes: straps pass a 2-FF sync, hence the 5-cycle holds
`timescale 1ns/1ps
module dcf_format_offset_assertions #(
  parameter int NUM_CH = dcf_pkg::NUM_CH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_code_format_select_pin,
  input wire logic i_single_supply,
  input wire dcf_pkg::dcf_bus_req_s i_bus,
  input wire logic [15:0] o_rdata,
  input wire dcf_pkg::dcf_core_s o_core,
  input wire logic o_ofs_amp_en
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle: assert property (
    !$past(i_bus.rd) |-> o_rdata == 16'h0000) else $error("read data outside slot");
  a_amp_single: assert property (
    i_single_supply [*5] |-> !o_ofs_amp_en && !o_core.ofs_en && o_core.ofs_a_core == 16'h0000)
    else $error("offset path on with single supply");
  a_amp_dual: assert property (
    !i_single_supply [*5] |-> o_ofs_amp_en) else $error("offset amp off on dual supply");
  a_gain_reload: assert property (
    $past(i_rst_n) && $changed(o_core.gain6) && o_ofs_amp_en |->
      {o_core.ofs_a_core, o_core.ofs_b_core} ==
      {2{o_core.gain6 ? dcf_pkg::OFS_DEF_G6 : dcf_pkg::OFS_DEF_G4}})
    else $error("offsets not reloaded on gain change");
  a_reset_vals: assert property (
    $rose(i_rst_n) |-> o_core.gain_cor == 16'h8000 && o_core.zero_cor == 16'h0000 && o_core.gain6)
    else $error("bad reset values");
  a_ofs_default: assert property (
    $rose(i_rst_n) && !i_single_supply |=> o_core.ofs_a_core == 16'h999A)
    else $error("offset default not loaded");
  a_fmt_conv: assert property (
    $stable(i_code_format_select_pin) [*4] ##0 i_bus.wr && i_bus.addr == 4'h0 |=>
      o_core.ch_core[0] == ($past(i_bus.wdata) ^ {i_code_format_select_pin, 15'h0000}))
    else $error("channel code conversion wrong");
  a_cor_read: assert property (
    i_bus.rd && i_bus.addr == 4'hA |=> o_rdata == o_core.gain_cor)
    else $error("gain correction read back wrong");
  c_gain_chg: cover property ($changed(o_core.gain6));
  c_single: cover property (i_single_supply [*5]);
  c_cfg_wr: cover property (i_bus.wr && i_bus.addr == 4'hC);
endmodule // dcf_format_offset_assertions
bind dcf_format_offset dcf_format_offset_assertions #(.NUM_CH(NUM_CH)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_code_format_select_pin(i_code_format_select_pin), .i_single_supply(i_single_supply),
  .i_bus(i_bus), .o_rdata(o_rdata), .o_core(o_core), .o_ofs_amp_en(o_ofs_amp_en));

// >>> dv/dcf_host_model.sv
// Purpose: host side driving the register port
// Assumes: one-cycle strobes set after the rising edge
// Notes: no release between calls, so one assignment per step
`timescale 1ns/1ps
module dcf_host_model (
  input wire logic i_ref_clk,
  output dcf_pkg::dcf_bus_req_s o_bus
);
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    o_bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge i_ref_clk);
  endtask
endmodule // dcf_host_model

// >>> dv/test_dcf_format_offset.sv
// Purpose: self-checking bench for the format and offset block
// Assumes: 20 MHz clock, sync active-low reset
// Notes: read results come off a queue one cycle after each read
`timescale 1ns/1ps
module test_dcf_format_offset;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fmt = 1'b0;
  logic single = 1'b0;
  dcf_pkg::dcf_bus_req_s bus;
  logic [15:0] rdata;
  dcf_pkg::dcf_core_s core;
  logic amp_en;
  logic [15:0] exp_q[$];
  logic [15:0] cs[3] = '{16'h0000, 16'h8000, 16'h7FFF};
  logic rd_q = 1'b0;
  logic [15:0] d;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  dcf_host_model u_host (.i_ref_clk(clk), .o_bus(bus));
  dcf_format_offset u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_code_format_select_pin(fmt),
    .i_single_supply(single), .i_bus(bus), .o_rdata(rdata), .o_core(core),
    .o_ofs_amp_en(amp_en));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    u_host.acc(1'b1, 1'b0, a, v);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.acc(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic idle(input int n);
    repeat (n) u_host.acc(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  // sync is cleared in reset, so a twos strap flips the offsets three edges after release
  task automatic do_reset(input logic f);
    rst_n <= 1'b0;
    fmt <= f;
    idle(5);
    rst_n <= 1'b1;
    idle(3);
  endtask
  task automatic codes();
    foreach (cs[i]) begin
      wr(4'h1, cs[i]);
      idle(1);
      chk(core.ch_core[1], cs[i] ^ {fmt, 15'h0000});
    end
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_q <= bus.rd;
    if (rd_q) chk(rdata, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    void'($urandom(7887));
    do_reset(1'b0);
    rd(4'hA, 16'h8000);
    rd(4'hB, 16'h0000);
    rd(4'h8, 16'h999A);
    rd(4'hD, 16'h000C);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      wr(i[3:0], d);
      rd(i[3:0], d);
    end
    codes();
    wr(4'h8, d);
    wr(4'h9, ~d);
    rd(4'h8, d);
    rd(4'h9, ~d);
    wr(4'hE, d);
    rd(4'hE, 16'h0000);
    wr(4'hC, 16'h0000);
    rd(4'h9, 16'hAAAB);
    rd(4'hD, 16'h0008);
    wr(4'h8, d);
    wr(4'hC, 16'h0000);
    rd(4'h8, d);
    wr(4'hC, 16'h0001);
    rd(4'h9, 16'h999A);
    do_reset(1'b1);
    rd(4'h8, 16'h199A);
    codes();
    wr(4'hC, 16'h0000);
    rd(4'h9, 16'h2AAB);
    wr(4'hA, d);
    wr(4'hB, d);
    rd(4'hA, d);
    chk(core.zero_cor, d);
    single <= 1'b1;
    idle(6);
    chk(16'(amp_en), 16'h0000);
    rd(4'hD, 16'h0003);
    idle(2);
    final_report();
  end
endmodule // test_dcf_format_offset
